/* rtl/cmp_defines.vh */
`ifndef CMP_DEFINES_VH
`define CMP_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CMP_ADDR_W        4
`define CMP_OFS_CTRL1     4'h0
`define CMP_OFS_SEL1      4'h1
`define CMP_OFS_CTRL2     4'h2
`define CMP_OFS_SEL2      4'h3
`define CMP_OFS_MIRROR    4'h4
`define CMP_OFS_IRQ_STAT  4'h5
`define CMP_OFS_IRQ_MASK  4'h6

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define CMP_RISE_BIT      7
`define CMP_FALL_BIT      6
`define CMP_POS_HI        5
`define CMP_POS_LO        4
`define CMP_NEG_HI        1
`define CMP_NEG_LO        0
`define CMP_SEL_MASK      8'hf3
`define CMP_CTRL_MASK     8'h01
`define CMP_FLAG_MASK     8'h03

// ----------------------------------------------------------------
// Selector codes and reset values
// ----------------------------------------------------------------
`define CMP_POS_PIN       2'h0
`define CMP_POS_DAC       2'h1
`define CMP_POS_FVR       2'h2
`define CMP_POS_ALT       2'h3
`define CMP_RST_VAL       8'h00

`endif

/* rtl/cmp_channel.v */
`include "cmp_defines.vh"

module cmp_channel #(
  parameter SECOND = 0
) (
  input  wire       core_clk,          // System clock
  input  wire       rst,               // Synchronous reset
  input  wire [7:0] sel_reg,           // Edge and input select register
  input  wire       result_bit,        // Comparator result bit
  input  wire       dedicated_pos,     // Own positive pin level code
  input  wire       shared_pos,        // Shared positive pin
  input  wire       dac_ref,           // DAC reference tap
  input  wire       fvr_ref,           // Fixed voltage reference tap
  input  wire [3:0] shared_neg,        // Shared negative pins 0..3
  output reg        noninverting_node, // Selected positive source
  output reg        inverting_node,    // Selected negative source
  output wire       edge_event         // One-cycle flag set request
);

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  reg prev_r;

  always @(posedge core_clk) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= result_bit;
    end
  end

  assign edge_event = (sel_reg[`CMP_RISE_BIT] & result_bit & ~prev_r) |
                      (sel_reg[`CMP_FALL_BIT] & ~result_bit & prev_r);

  // ----------------------------------------------------------------
  // Input steering
  // ----------------------------------------------------------------
  // Modelled as select codes driving a digital mux; the analog switch sits outside
  always @* begin
    case (sel_reg[`CMP_POS_HI:`CMP_POS_LO])
      `CMP_POS_PIN: noninverting_node = dedicated_pos;
      `CMP_POS_DAC: noninverting_node = dac_ref;
      `CMP_POS_FVR: noninverting_node = fvr_ref;
      default:      noninverting_node = (SECOND != 0) ? 1'b0 : shared_pos;
    endcase
  end

  always @* begin
    inverting_node = shared_neg[sel_reg[`CMP_NEG_HI:`CMP_NEG_LO]];
  end

endmodule

/* rtl/cmp_edge_irq.v */
`include "cmp_defines.vh"

module cmp_edge_irq (
  input  wire                   core_clk,       // System clock
  input  wire                   rst,            // Synchronous reset, active high
  input  wire [`CMP_ADDR_W-1:0] addr,           // Register address
  input  wire [7:0]             wdata,          // Write data
  input  wire                   wr,             // Write strobe
  input  wire                   rd,             // Read strobe
  output reg  [7:0]             rdata,          // Read data, cycle after rd
  input  wire                   result_first,   // First comparator result bit
  input  wire                   result_second,  // Second comparator result bit
  input  wire                   dedicated_pos1, // First dedicated positive pin
  input  wire                   dedicated_pos2, // Second dedicated positive pin
  input  wire                   shared_pos,     // Shared positive pin
  input  wire                   dac_ref,        // DAC reference
  input  wire                   fvr_ref,        // Fixed voltage reference
  input  wire [3:0]             shared_neg,     // Shared negative pins
  output wire                   ninv_first,     // First non-inverting node
  output wire                   inv_first,      // First inverting node
  output wire                   ninv_second,    // Second non-inverting node
  output wire                   inv_second,     // Second inverting node
  output reg                    comparator_on1, // First comparator enable
  output reg                    comparator_on2, // Second comparator enable
  output wire [1:0]             comparator_irq_flag, // Sticky flags
  output wire                   irq             // Level interrupt
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0] sel1_r;
  reg  [7:0] sel2_r;
  reg  [1:0] flag_r;
  reg  [1:0] mask_r;
  reg  [1:0] mirror_r;
  reg  [1:0] flag_nxt;
  wire       ev1;
  wire       ev2;
  wire       wr_ctrl1;
  wire       wr_ctrl2;
  wire       rd_stat;

  assign wr_ctrl1 = wr & (addr == `CMP_OFS_CTRL1);
  assign wr_ctrl2 = wr & (addr == `CMP_OFS_CTRL2);
  assign rd_stat  = rd & (addr == `CMP_OFS_IRQ_STAT);

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  cmp_channel #(.SECOND(0)) u_ch1 (
    .core_clk          (core_clk),
    .rst               (rst),
    .sel_reg           (sel1_r),
    .result_bit        (result_first),
    .dedicated_pos     (dedicated_pos1),
    .shared_pos        (shared_pos),
    .dac_ref           (dac_ref),
    .fvr_ref           (fvr_ref),
    .shared_neg        (shared_neg),
    .noninverting_node (ninv_first),
    .inverting_node    (inv_first),
    .edge_event        (ev1)
  );

  cmp_channel #(.SECOND(1)) u_ch2 (
    .core_clk          (core_clk),
    .rst               (rst),
    .sel_reg           (sel2_r),
    .result_bit        (result_second),
    .dedicated_pos     (dedicated_pos2),
    .shared_pos        (shared_pos),
    .dac_ref           (dac_ref),
    .fvr_ref           (fvr_ref),
    .shared_neg        (shared_neg),
    .noninverting_node (ninv_second),
    .inverting_node    (inv_second),
    .edge_event        (ev2)
  );

  // ----------------------------------------------------------------
  // Flags: a read of the status register clears, an edge in the same cycle wins
  // ----------------------------------------------------------------
  always @* begin
    flag_nxt = rd_stat ? 2'h0 : flag_r;
    flag_nxt = flag_nxt | {ev2, ev1};
  end

  assign comparator_irq_flag = flag_r;
  assign irq = |(flag_r & mask_r);

  always @(posedge core_clk) begin
    if (rst) begin
      sel1_r         <= `CMP_RST_VAL;
      sel2_r         <= `CMP_RST_VAL;
      flag_r         <= 2'h0;
      mask_r         <= 2'h0;
      mirror_r       <= 2'h0;
      comparator_on1 <= 1'b0;
      comparator_on2 <= 1'b0;
    end else begin
      flag_r   <= flag_nxt;
      mirror_r <= {result_second, result_first};
      if (wr_ctrl1) begin
        comparator_on1 <= wdata[0];
      end
      if (wr_ctrl2) begin
        comparator_on2 <= wdata[0];
      end
      if (wr & (addr == `CMP_OFS_SEL1)) begin
        sel1_r <= wdata & `CMP_SEL_MASK;
      end
      if (wr & (addr == `CMP_OFS_SEL2)) begin
        sel2_r <= wdata & `CMP_SEL_MASK;
      end
      if (wr & (addr == `CMP_OFS_IRQ_MASK)) begin
        mask_r <= wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `CMP_OFS_CTRL1:    rdata <= {7'h00, comparator_on1};
        `CMP_OFS_CTRL2:    rdata <= {7'h00, comparator_on2};
        `CMP_OFS_SEL1:     rdata <= sel1_r;
        `CMP_OFS_SEL2:     rdata <= sel2_r;
        `CMP_OFS_MIRROR:   rdata <= {6'h00, mirror_r};
        `CMP_OFS_IRQ_STAT: rdata <= {6'h00, flag_r};
        `CMP_OFS_IRQ_MASK: rdata <= {6'h00, mask_r};
        default:           rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

/* verification/cmp_edge_irq_chk.sv */
module cmp_edge_irq_chk (
  input logic       core_clk, rst, wr, rd, irq,
  input logic [3:0] addr, shared_neg,
  input logic [7:0] wdata, rdata,
  input logic       result_first, result_second, dedicated_pos1, dedicated_pos2,
  input logic       shared_pos, dac_ref, fvr_ref,
  input logic       ninv_first, inv_first, ninv_second, inv_second,
  input logic [1:0] comparator_irq_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Shadow registers, loaded on the same edge as the design's
  // ------------------------------------------------------------
  logic [7:0] sel1_r, sel2_r, msk_r;
  logic [3:0] src1, src2;
  always_ff @(posedge core_clk) sel1_r <= rst ? 8'h00 : (wr && addr == 4'h1) ? wdata : sel1_r;
  always_ff @(posedge core_clk) sel2_r <= rst ? 8'h00 : (wr && addr == 4'h3) ? wdata : sel2_r;
  always_ff @(posedge core_clk) msk_r <= rst ? 8'h00 : (wr && addr == 4'h6) ? wdata : msk_r;
  // Second channel grounds its positive input on code 11
  assign src1 = {shared_pos, fvr_ref, dac_ref, dedicated_pos1};
  assign src2 = {1'b0, fvr_ref, dac_ref, dedicated_pos2};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  rise_first_a : assert property ($rose(result_first) && sel1_r[7] |-> ##[1:2] comparator_irq_flag[0])
    else $error("first flag not set on rising result");
  fall_second_a : assert property ($fell(result_second) && sel2_r[6] |-> ##[1:2] comparator_irq_flag[1])
    else $error("second flag not set on falling result");
  pos_first_a : assert property (ninv_first == src1[sel1_r[5:4]])
    else $error("first positive input wrongly routed");
  pos_second_a : assert property (ninv_second == src2[sel2_r[5:4]])
    else $error("second positive input wrongly routed");
  neg_route_a : assert property (inv_first == shared_neg[sel1_r[1:0]] && inv_second == shared_neg[sel2_r[1:0]])
    else $error("negative input wrongly routed");
  mirror_read_a : assert property (rd && addr == 4'h4 |=> rdata == {6'h00, $past(result_second, 2), $past(result_first, 2)})
    else $error("mirror read data wrong");
  sel_unused_a : assert property (rd && addr == 4'h1 |=> rdata[3:2] == 2'h0)
    else $error("unused select bits not zero");
  irq_level_a : assert property (irq == |(comparator_irq_flag & msk_r[1:0]))
    else $error("interrupt level wrong");
endmodule

/* verification/comparator_edge_irq_input_select_bench.sv */
module comparator_edge_irq_input_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 0, rst = 1, wr = 0, rd = 0, result_first = 0, result_second = 0;
  logic       dedicated_pos1 = 0, dedicated_pos2 = 0, shared_pos = 0, dac_ref = 0, fvr_ref = 0;
  logic [3:0] addr = 0, shared_neg = 0, s;
  logic [7:0] wdata = 0, rdata, got;
  logic [1:0] comparator_irq_flag;
  logic       irq, ninv_first, inv_first, ninv_second, inv_second, comparator_on1, comparator_on2;
  logic [3:0] pats [4] = '{4'h5, 4'h3, 4'ha, 4'hc};
  int         fail_count = 0, samples_checked = 0, cycles = 0;
  cmp_edge_irq cmp_edge_irq_inst (.*);
  initial forever #4 core_clk = ~core_clk;
  // Tests take a few hundred cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  // ------------------------------------------------------------
  // Bus access and comparison
  // ------------------------------------------------------------
  task chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task rd_reg(logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task pulse(int c, logic v);
    @(posedge core_clk);
    if (c == 1) result_second <= v;
    else result_first <= v;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task finish_test();
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd_reg(4'h4); chk("mirror", 8'h00, got);
    wr_reg(4'h1, 8'hff); rd_reg(4'h1); chk("sel1", 8'hf3, got);
    wr_reg(4'h4, 8'hff); rd_reg(4'h4); chk("mirror", 8'h00, got);
    wr_reg(4'h0, 8'hff); rd_reg(4'h0); chk("ctrl1", 8'h01, got);
    wr_reg(4'h2, 8'hfe); rd_reg(4'h2); chk("ctrl2", 8'h00, got);
    chk("enables", 8'h01, {6'h00, comparator_on2, comparator_on1});
    rd_reg(4'h7); chk("unmapped", 8'h00, got);
    wr_reg(4'h6, 8'h03);
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        wr_reg(c == 1 ? 4'h3 : 4'h1, {m[1:0], 6'h00});
        pulse(c, 1'b1);
        chk("irq", {7'h00, m[1]}, {7'h00, irq});
        rd_reg(4'h5); chk("rise flag", m[1] ? 8'h01 << c : 8'h00, got);
        rd_reg(4'h4); chk("mirror", 8'h01 << c, got);
        pulse(c, 1'b0);
        rd_reg(4'h5); chk("fall flag", m[0] ? 8'h01 << c : 8'h00, got);
      end
    end
    // A masked flag stays pending but keeps the interrupt low
    wr_reg(4'h6, 8'h00); wr_reg(4'h1, 8'h80); pulse(0, 1'b1);
    chk("masked irq", 8'h00, {7'h00, irq});
    rd_reg(4'h5); chk("masked flag", 8'h01, got);
    for (int p = 0; p < 4; p++) begin
      wr_reg(4'h1, {2'h0, p[1:0], 2'h0, p[1:0]});
      wr_reg(4'h3, {2'h0, p[1:0], 2'h0, p[1:0]});
      for (int k = 0; k < 4; k++) begin
        s = pats[k];
        @(posedge core_clk);
        dedicated_pos1 <= s[0]; dac_ref <= s[1]; fvr_ref <= s[2]; shared_pos <= s[3];
        dedicated_pos2 <= ~s[0]; shared_neg <= s;
        @(posedge core_clk);
        #1;
        chk("pos1", {7'h00, s[p]}, {7'h00, ninv_first});
        chk("neg", {6'h00, s[p], s[p]}, {6'h00, inv_first, inv_second});
        chk("pos2", p == 0 ? {7'h00, ~s[0]} : p == 3 ? 8'h00 : {7'h00, s[p]},
            {7'h00, ninv_second});
      end
    end
    finish_test();
  end
endmodule
bind cmp_edge_irq cmp_edge_irq_chk cmp_edge_irq_chk_inst (.*);
